/* core/opd_dec_if.sv */
`timescale 1ns/100ps
interface opd_dec_if;
  logic [7:0] opcode;              // opcode byte being decoded
  logic prefix;                    // previous byte was the page prefix
  opd_pkg::opd_mode_t mode;        // addressing mode
  logic [1:0] length;              // bytes without the prefix
  logic [3:0] cycles;              // total bus cycles
  logic need_rd;                   // operand read
  logic need_wr;                   // operand write
  logic need_push;                 // one stack push
  logic need_pop;                  // one stack pop
  logic is_branch;                 // ends with a conditional branch
  logic is_prefix;                 // this byte is the prefix
  logic illegal;                   // undefined opcode
  logic [2:0] bit_index;           // bit number for bit ops
  modport dec (input opcode, input prefix, output mode, output length, output cycles,
               output need_rd, output need_wr, output need_push, output need_pop,
               output is_branch, output is_prefix, output illegal, output bit_index);
  modport host (output opcode, output prefix, input mode, input length, input cycles,
                input need_rd, input need_wr, input need_push, input need_pop,
                input is_branch, input is_prefix, input illegal, input bit_index);
endinterface

/* core/opd_decode.sv */
`timescale 1ns/100ps
module opd_decode (
  // decode request and result
  opd_dec_if.dec dif
);

  logic [3:0] hi;  // opcode column
  logic [3:0] lo;  // opcode row
  logic st;        // store-type row

  assign hi = dif.opcode[7:4];
  assign lo = dif.opcode[3:0];
  assign st = (lo == 4'h7) || (lo == 4'hf);
  // bit number sits in opcode bits 3..1
  assign dif.bit_index = dif.opcode[3:1];

  // opcode map to mode, length and cycles
  always_comb begin
    dif.mode = opd_pkg::MD_IMPLIED;
    dif.length = 2'h1;
    dif.cycles = 4'h1;
    dif.need_rd = 1'b0;
    dif.need_wr = 1'b0;
    dif.need_push = 1'b0;
    dif.need_pop = 1'b0;
    dif.is_branch = 1'b0;
    dif.is_prefix = 1'b0;
    dif.illegal = 1'b0;
    unique case (hi)
      // test bit and branch, set or clear bit
      4'h0, 4'h1: begin
        dif.mode = opd_pkg::MD_PAGE_ZERO;
        dif.length = (hi == 4'h0) ? 2'h3 : 2'h2;
        dif.cycles = 4'h5;
        dif.need_rd = 1'b1;
        dif.need_wr = (hi == 4'h1);
        dif.is_branch = (hi == 4'h0);
      end
      // branches
      4'h2: begin
        dif.mode = opd_pkg::MD_RELATIVE;
        dif.length = 2'h2;
        dif.cycles = 4'h3;
        dif.is_branch = 1'b1;
      end
      // read-modify-write on the first page
      4'h3: begin
        dif.mode = opd_pkg::MD_PAGE_ZERO;
        dif.length = 2'h2;
        dif.cycles = 4'h5;
        dif.need_rd = (lo != 4'h5);
        dif.need_wr = (lo != 4'h1) && (lo != 4'h2) && (lo != 4'he);
        if ((lo == 4'h2) || (lo == 4'he)) begin
          dif.mode = opd_pkg::MD_FULL_ADDRESS;
          dif.length = 2'h3;
        end
        if ((lo == 4'h1) || (lo == 4'hb)) begin
          dif.length = 2'h3;
          dif.is_branch = 1'b1;
        end
      end
      // accumulator and index forms, compare literals, moves
      4'h4, 4'h5: begin
        if (lo == 4'h1) begin
          dif.mode = opd_pkg::MD_LITERAL_OPERAND;
          dif.length = 2'h3;
          dif.cycles = 4'h4;
          dif.is_branch = 1'b1;
        end else if (lo == 4'h5) begin
          dif.mode = (hi == 4'h4) ? opd_pkg::MD_LITERAL_OPERAND : opd_pkg::MD_PAGE_ZERO;
          dif.length = (hi == 4'h4) ? 2'h3 : 2'h2;  // word literal is two bytes
          dif.cycles = (hi == 4'h4) ? 4'h3 : 4'h4;
          dif.need_rd = (hi == 4'h5);
        end else if (lo == 4'hb) begin
          dif.mode = opd_pkg::MD_RELATIVE;
          dif.length = 2'h2;
          dif.cycles = 4'h4;
          dif.is_branch = 1'b1;
        end else if (lo == 4'he) begin
          dif.length = (hi == 4'h4) ? 2'h3 : 2'h2;
          dif.cycles = 4'h5;
        end
      end
      // short pointer offset
      4'h6: begin
        dif.mode = (lo == 4'h1) ? opd_pkg::MD_POINTER_OFS_INC : opd_pkg::MD_POINTER_SHORT;
        dif.length = ((lo == 4'h1) || (lo == 4'hb)) ? 2'h3 : 2'h2;
        dif.cycles = 4'h5;
        dif.need_rd = 1'b1;
        dif.need_wr = (lo != 4'h1);
        dif.is_branch = (lo == 4'h1) || (lo == 4'hb);
        if ((lo == 4'h2) || (lo == 4'h5) || (lo == 4'he)) begin
          dif.mode = (lo == 4'h2) ? opd_pkg::MD_IMPLIED : opd_pkg::MD_LITERAL_OPERAND;
          dif.length = (lo == 4'h2) ? 2'h1 : 2'h3;
          dif.cycles = (lo == 4'h2) ? 4'h1 : 4'h3;
          dif.need_rd = 1'b0;
          dif.need_wr = 1'b0;
        end
      end
      // plain pointer
      4'h7: begin
        dif.mode = (lo == 4'h1) ? opd_pkg::MD_POINTER_AUTOINC : opd_pkg::MD_POINTER_PLAIN;
        dif.length = ((lo == 4'h1) || (lo == 4'hb)) ? 2'h2 : 2'h1;
        dif.cycles = 4'h4;
        dif.need_rd = (lo != 4'h2) && (lo != 4'he);
        dif.need_wr = (lo != 4'h1) && (lo != 4'h2) && (lo != 4'h5);
        dif.is_branch = (lo == 4'h1) || (lo == 4'hb);
        if ((lo == 4'h5) || (lo == 4'he)) begin
          dif.mode = opd_pkg::MD_PAGE_ZERO;
          dif.length = 2'h2;
        end
      end
      // control: stack transfers
      4'h8: begin
        dif.need_pop = (lo == 4'h6) || (lo == 4'h8) || (lo == 4'ha);
        dif.need_push = (lo == 4'h7) || (lo == 4'h9) || (lo == 4'hb);
        dif.cycles = dif.need_pop ? 4'h3 : (dif.need_push ? 4'h2 : 4'h1);
        if (lo == 4'h3) begin
          dif.cycles = 4'hb;
        end
      end
      // signed branches, transfers, prefix
      4'h9: begin
        dif.is_prefix = (lo == 4'he);
        if (lo <= 4'h3) begin
          dif.mode = opd_pkg::MD_RELATIVE;
          dif.length = 2'h2;
          dif.cycles = 4'h3;
          dif.is_branch = 1'b1;
        end else if (lo == 4'h6) begin
          // word store to a full address
          dif.mode = opd_pkg::MD_FULL_ADDRESS;
          dif.length = 2'h3;
          dif.cycles = 4'h5;
          dif.need_wr = 1'b1;
        end
      end
      // literal operand
      4'ha: begin
        dif.mode = (lo == 4'hd) ? opd_pkg::MD_RELATIVE : opd_pkg::MD_LITERAL_OPERAND;
        dif.length = 2'h2;
        dif.cycles = (lo == 4'hd) ? 4'h5 : 4'h2;
      end
      // register and memory columns
      default: begin
        dif.mode = (hi == 4'hb) ? opd_pkg::MD_PAGE_ZERO :
                   (hi == 4'hc) ? opd_pkg::MD_FULL_ADDRESS :
                   (hi == 4'hd) ? opd_pkg::MD_POINTER_LONG :
                   (hi == 4'he) ? opd_pkg::MD_POINTER_SHORT : opd_pkg::MD_POINTER_PLAIN;
        dif.length = ((hi == 4'hc) || (hi == 4'hd)) ? 2'h3 : ((hi == 4'hf) ? 2'h1 : 2'h2);
        dif.cycles = ((hi == 4'hc) || (hi == 4'hd)) ? 4'h4 : 4'h3;
        dif.need_rd = !st;
        dif.need_wr = st;
      end
    endcase
    // second page: offset pointer columns (6, d, e) become stack offsets, the rest are illegal
    if (dif.prefix) begin
      dif.is_prefix = 1'b0;
      dif.cycles = dif.cycles + 4'h1;
      if ((hi == 4'h6) || (hi == 4'he)) begin
        dif.mode = opd_pkg::MD_STACK_SHORT;
      end else if (hi == 4'hd) begin
        dif.mode = opd_pkg::MD_STACK_LONG;
      end else begin
        dif.illegal = 1'b1;  // undefined on this page
      end
    end
    // illegal opcodes do no operand reads, writes or branch; a decoded push or pop stays
    if (dif.illegal) begin
      dif.length = 2'h1;
      dif.cycles = 4'h1;
      dif.need_rd = 1'b0;
      dif.need_wr = 1'b0;
      dif.is_branch = 1'b0;
    end
  end

endmodule

/* core/opd_pkg.sv */
package opd_pkg;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_VEC_HI  = 8'h01,
    ST_VEC_LO  = 8'h02,
    ST_OPCODE  = 8'h04,
    ST_OPERAND = 8'h08,
    ST_ACCESS  = 8'h10,
    ST_PUSH    = 8'h20,
    ST_POP     = 8'h40,
    ST_FREE    = 8'h80
  } opd_state_t;

  // addressing modes
  typedef enum logic [3:0] {
    MD_IMPLIED          = 4'h0,
    MD_LITERAL_OPERAND  = 4'h1,
    MD_PAGE_ZERO        = 4'h2,
    MD_FULL_ADDRESS     = 4'h3,
    MD_RELATIVE         = 4'h4,
    MD_POINTER_PLAIN    = 4'h5,
    MD_POINTER_SHORT    = 4'h6,
    MD_POINTER_LONG     = 4'h7,
    MD_POINTER_AUTOINC  = 4'h8,
    MD_POINTER_OFS_INC  = 4'h9,
    MD_STACK_SHORT      = 4'ha,
    MD_STACK_LONG       = 4'hb
  } opd_mode_t;

  // kind of the bus cycle in progress
  typedef enum logic [2:0] {
    KIND_FETCH  = 3'h0,
    KIND_READ   = 3'h1,
    KIND_WRITE  = 3'h2,
    KIND_PUSH   = 3'h3,
    KIND_POP    = 3'h4,
    KIND_VECTOR = 3'h5,
    KIND_FREE   = 3'h6
  } opd_kind_t;

  // vector bytes in the top page, high byte read first
  localparam logic [15:0] VEC_ADDR_HI = 16'hfffe;
  localparam logic [15:0] VEC_ADDR_LO = 16'hffff;
  // opcode that selects the stack-offset page
  localparam logic [7:0] PAGE_TWO_PREFIX = 8'h9e;
  // high address byte of the first page
  localparam logic [7:0] PAGE_ZERO_HIGH = 8'h00;
  // values after reset
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // cycle count of the opcode fetch itself
  localparam logic [3:0] CYC_FIRST = 4'h1;

endpackage

/* core/opd_sequencer.sv */
//
// Summary of operation
// - free cycle: one clock, signalled read
// - program fetch reads next byte, advances counter
// - vector read from top page, high first
// - push writes one byte at stack pointer
// - pop reads exactly one stack byte
// - branch target: next instruction plus signed offset
// - page-zero mode: one byte, high byte zero
// - full address mode: two operand bytes
// - literal: one byte, or two for words
// - short pointer offset: unsigned byte plus pointer
// - long pointer offset: word plus pointer
// - autoincrement: access via pointer, then increment
// - stack short offset: pointer plus byte
// - stack long offset: pointer plus word
// - bit ops: bit number 0-7 in opcode
`timescale 1ns/100ps
module opd_sequencer (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // system bus
  output logic [15:0] bus_addr,
  output logic bus_rd,
  output logic bus_wr,
  output logic [7:0] bus_wdata,
  output opd_pkg::opd_kind_t cycle_kind,
  input wire logic [7:0] bus_rdata,
  // datapath inputs
  input wire logic [15:0] index_pair,
  input wire logic [15:0] stack_pointer,
  input wire logic [7:0] store_data,
  input wire logic branch_taken,
  // datapath outputs
  output logic [7:0] opcode,
  output logic page_two,
  output logic [15:0] operand,
  output logic [7:0] read_data,
  output logic [2:0] bit_index,
  output logic index_inc,
  output logic push_done,
  output logic pop_done,
  output logic instr_done,
  output logic illegal_opcode
);

  opd_pkg::opd_state_t state;       // cycle now on the bus
  opd_pkg::opd_state_t next_state;  // cycle to issue next
  logic [15:0] program_counter;     // address of next program byte
  logic [1:0] opr_left;             // operand bytes still to fetch
  logic need_rd;                    // operand read pending
  logic need_wr;                    // operand write pending
  logic need_push;                  // push pending
  logic need_pop;                   // pop pending
  logic [3:0] used;                 // cycles spent on this instruction
  logic [1:0] next_opr_left;
  logic next_rd;
  logic next_wr;
  logic next_push;
  logic next_pop;
  logic [3:0] next_used;
  logic [15:0] next_oper;           // operand bytes, last one low
  logic [15:0] next_addr;
  logic next_bus_rd;
  logic next_bus_wr;
  opd_pkg::opd_kind_t next_kind;
  logic [15:0] next_pc;
  logic refetch;                    // prefix seen, fetch real opcode
  logic finish;                     // instruction ends this cycle
  logic take_branch;
  logic autoinc;
  logic [7:0] short_ofs;            // one-byte offset or page address
  logic [15:0] fetch_pc;            // where the next opcode would be
  logic [15:0] ea;                  // effective address
  logic [15:0] branch_target;

  opd_dec_if dif ();

  // decode the live byte while it is on the bus, else the held opcode
  assign dif.opcode = (state == opd_pkg::ST_OPCODE) ? bus_rdata : opcode;
  assign dif.prefix = page_two;

  opd_decode u_decode (
    .dif(dif)
  );

  assign autoinc = (dif.mode == opd_pkg::MD_POINTER_AUTOINC) ||
                   (dif.mode == opd_pkg::MD_POINTER_OFS_INC);

  // progress bookkeeping for the cycle now ending
  always_comb begin
    next_opr_left = opr_left;
    next_rd = need_rd;
    next_wr = need_wr;
    next_push = need_push;
    next_pop = need_pop;
    next_oper = operand;
    next_used = used + 4'h1;
    refetch = 1'b0;
    unique case (state)
      opd_pkg::ST_OPCODE: begin
        if (dif.is_prefix) begin
          refetch = 1'b1;
        end else begin
          // operand byte count from the decoded length
          next_opr_left = dif.length - 2'h1;
          next_rd = dif.need_rd;
          next_wr = dif.need_wr;
          next_push = dif.need_push;
          next_pop = dif.need_pop;
        end
      end
      opd_pkg::ST_OPERAND: begin
        // shift in operand bytes, first byte ends up high
        next_opr_left = opr_left - 2'h1;
        next_oper = {operand[7:0], bus_rdata};
      end
      opd_pkg::ST_ACCESS: begin
        if (bus_rd) begin
          next_rd = 1'b0;
        end else begin
          next_wr = 1'b0;
        end
      end
      opd_pkg::ST_PUSH: begin
        next_push = 1'b0;
      end
      opd_pkg::ST_POP: begin
        next_pop = 1'b0;
      end
      opd_pkg::ST_VEC_HI, opd_pkg::ST_VEC_LO, opd_pkg::ST_FREE: begin
      end
    endcase
  end

  // effective address per mode
  always_comb begin
    // three-byte forms carry the address byte first, branch byte last
    short_ofs = (dif.length == 2'h3) ? next_oper[15:8] : next_oper[7:0];
    unique case (dif.mode)
      opd_pkg::MD_PAGE_ZERO: ea = {opd_pkg::PAGE_ZERO_HIGH, short_ofs};
      opd_pkg::MD_FULL_ADDRESS: ea = next_oper;
      opd_pkg::MD_POINTER_PLAIN, opd_pkg::MD_POINTER_AUTOINC: ea = index_pair;
      opd_pkg::MD_POINTER_SHORT, opd_pkg::MD_POINTER_OFS_INC:
        ea = index_pair + {8'h00, short_ofs};
      opd_pkg::MD_POINTER_LONG: ea = index_pair + next_oper;
      opd_pkg::MD_STACK_SHORT: ea = stack_pointer + {8'h00, short_ofs};
      opd_pkg::MD_STACK_LONG: ea = stack_pointer + next_oper;
      default: ea = next_oper;
    endcase
  end

  // choose the next bus cycle
  always_comb begin
    fetch_pc = (state == opd_pkg::ST_VEC_LO) ? {program_counter[15:8], bus_rdata}
                                             : program_counter;
    // counter already points past the instruction
    branch_target = fetch_pc + {{8{next_oper[7]}}, next_oper[7:0]};
    take_branch = dif.is_branch && branch_taken;
    next_state = opd_pkg::ST_FREE;
    next_addr = program_counter;
    next_bus_rd = 1'b1;
    next_bus_wr = 1'b0;
    next_kind = opd_pkg::KIND_FREE;
    next_pc = program_counter;
    finish = 1'b0;
    if (state == opd_pkg::ST_VEC_HI) begin
      // low vector byte follows the high one
      next_state = opd_pkg::ST_VEC_LO;
      next_addr = opd_pkg::VEC_ADDR_LO;
      next_kind = opd_pkg::KIND_VECTOR;
      next_pc = {bus_rdata, 8'h00};
    end else if ((state == opd_pkg::ST_VEC_LO) || refetch) begin
      next_state = opd_pkg::ST_OPCODE;
      next_addr = fetch_pc;
      next_kind = opd_pkg::KIND_FETCH;
      next_pc = fetch_pc + 16'h0001;
    end else if (next_opr_left != 2'h0) begin
      next_state = opd_pkg::ST_OPERAND;
      next_kind = opd_pkg::KIND_FETCH;
      next_pc = program_counter + 16'h0001;
    end else if (next_rd || next_wr) begin
      next_state = opd_pkg::ST_ACCESS;
      next_addr = ea;
      next_bus_rd = next_rd;
      next_bus_wr = !next_rd;
      next_kind = next_rd ? opd_pkg::KIND_READ : opd_pkg::KIND_WRITE;
    end else if (next_push) begin
      // one byte written at the stack pointer
      next_state = opd_pkg::ST_PUSH;
      next_addr = stack_pointer;
      next_bus_rd = 1'b0;
      next_bus_wr = 1'b1;
      next_kind = opd_pkg::KIND_PUSH;
    end else if (next_pop) begin
      // one byte read just above the stack pointer
      next_state = opd_pkg::ST_POP;
      next_addr = stack_pointer + 16'h0001;
      next_kind = opd_pkg::KIND_POP;
    end else if (next_used <= dif.cycles) begin
      // pad to the decoded count with free reads
      next_state = opd_pkg::ST_FREE;
    end else begin
      finish = 1'b1;
      next_state = opd_pkg::ST_OPCODE;
      next_addr = take_branch ? branch_target : fetch_pc;
      next_kind = opd_pkg::KIND_FETCH;
      next_pc = next_addr + 16'h0001;
    end
  end

  // bus cycle registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // reset starts the vector read
      state <= opd_pkg::ST_VEC_HI;
      bus_addr <= opd_pkg::VEC_ADDR_HI;
      bus_rd <= 1'b1;
      bus_wr <= 1'b0;
      bus_wdata <= opd_pkg::RST_BYTE;
      cycle_kind <= opd_pkg::KIND_VECTOR;
      program_counter <= opd_pkg::RST_PC;
    end else begin
      state <= next_state;
      bus_addr <= next_addr;
      bus_rd <= next_bus_rd;
      bus_wr <= next_bus_wr;
      bus_wdata <= store_data;
      cycle_kind <= next_kind;
      program_counter <= next_pc;
    end
  end

  // per-instruction progress
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      opr_left <= 2'h0;
      need_rd <= 1'b0;
      need_wr <= 1'b0;
      need_push <= 1'b0;
      need_pop <= 1'b0;
      used <= opd_pkg::CYC_FIRST;
    end else begin
      opr_left <= next_opr_left;
      need_rd <= next_rd;
      need_wr <= next_wr;
      need_push <= next_push;
      need_pop <= next_pop;
      // prefix cycle counts toward the instruction
      used <= (next_state == opd_pkg::ST_OPCODE && !refetch) ? opd_pkg::CYC_FIRST : next_used;
    end
  end

  // results and pulses towards the datapath
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      opcode <= opd_pkg::RST_BYTE;
      page_two <= 1'b0;
      operand <= 16'h0000;
      read_data <= opd_pkg::RST_BYTE;
      bit_index <= 3'h0;
      index_inc <= 1'b0;
      push_done <= 1'b0;
      pop_done <= 1'b0;
      instr_done <= 1'b0;
      illegal_opcode <= 1'b0;
    end else begin
      if (state == opd_pkg::ST_OPCODE) begin
        opcode <= bus_rdata;
        bit_index <= dif.bit_index;
      end
      if ((state == opd_pkg::ST_OPCODE) && dif.is_prefix) begin
        page_two <= 1'b1;
      end else if (finish) begin
        page_two <= 1'b0;
      end
      operand <= next_oper;
      if (((state == opd_pkg::ST_ACCESS) && bus_rd) || (state == opd_pkg::ST_POP)) begin
        read_data <= bus_rdata;
      end
      // bump the pointer once its last access is done
      index_inc <= (state == opd_pkg::ST_ACCESS) && autoinc && !next_rd && !next_wr;
      push_done <= (state == opd_pkg::ST_PUSH);
      pop_done <= (state == opd_pkg::ST_POP);
      instr_done <= finish;
      illegal_opcode <= (state == opd_pkg::ST_OPCODE) && dif.illegal;
    end
  end

  a_free_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == opd_pkg::ST_FREE) |-> bus_rd && !bus_wr && (cycle_kind == opd_pkg::KIND_FREE))
    else $error("free cycle not a plain read");

  a_fetch_advance: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == opd_pkg::ST_OPERAND) |-> (program_counter == bus_addr + 16'h0001) && bus_rd)
    else $error("program counter not past fetched byte");

  a_vector_order: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == opd_pkg::ST_VEC_HI) |-> (bus_addr == opd_pkg::VEC_ADDR_HI)
      ##1 (state == opd_pkg::ST_VEC_LO) && (bus_addr == opd_pkg::VEC_ADDR_LO))
    else $error("vector bytes out of order");

  a_push_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == opd_pkg::ST_PUSH) |-> bus_wr && !bus_rd && (bus_addr == $past(stack_pointer))
      ##1 (state != opd_pkg::ST_PUSH))
    else $error("push not a single write at stack pointer");

  a_pop_once: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state == opd_pkg::ST_POP) |-> bus_rd && !bus_wr ##1 (state != opd_pkg::ST_POP) && pop_done)
    else $error("pop not a single read");

  a_branch_target: assert property (@(posedge core_clk) disable iff (!reset_n)
    (finish && take_branch) |=>
      (bus_addr == $past(fetch_pc) + {{8{operand[7]}}, operand[7:0]}))
    else $error("branch target wrong");

  a_page_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((state == opd_pkg::ST_ACCESS) && (dif.mode == opd_pkg::MD_PAGE_ZERO))
      |-> (bus_addr[15:8] == opd_pkg::PAGE_ZERO_HIGH))
    else $error("page-zero access left the first page");

  a_pointer_short: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((state == opd_pkg::ST_ACCESS) && (dif.mode == opd_pkg::MD_POINTER_SHORT))
      |-> (bus_addr == $past(index_pair) + {8'h00, operand[7:0]}))
    else $error("short pointer offset address wrong");

  a_index_bump: assert property (@(posedge core_clk) disable iff (!reset_n)
    index_inc |-> ($past(state) == opd_pkg::ST_ACCESS) ##1 !index_inc)
    else $error("pointer bump not after its access");

  a_illegal_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    illegal_opcode |-> ($past(state) == opd_pkg::ST_OPCODE) && (state == opd_pkg::ST_OPCODE))
    else $error("illegal flag without an opcode");

endmodule

/* verification/cpu_opcode_addressing_decoder_tb_top.sv */
`timescale 1ns/100ps
module cpu_opcode_addressing_decoder_tb_top;
  logic core_clk, reset_n, bus_rd, bus_wr, branch_taken, page_two, index_inc;
  logic push_done, pop_done, instr_done, illegal_opcode;
  logic [15:0] bus_addr, index_pair, stack_pointer, operand;
  logic [7:0] bus_wdata, bus_rdata, store_data, opcode, read_data;
  logic [2:0] bit_index;
  opd_pkg::opd_kind_t cycle_kind;
  int miscompares = 0, checks = 0, cycles = 0;
  // program at 1000: ext load, page-zero load, push, pull, short pointer load, branch
  logic [7:0] prog [0:10] = '{8'hc6, 8'h12, 8'h34, 8'hb6, 8'h40, 8'h87, 8'h86,
                               8'he6, 8'hff, 8'h20, 8'h80};
  // program at 0f8d for the remaining modes except plain pointer and offset with autoincrement
  logic [7:0] prog2 [0:15] = '{8'hd6, 8'h01, 8'h00, 8'h9e, 8'he6, 8'h10, 8'h71, 8'h05,
                                8'h9e, 8'hd6, 8'h00, 8'h08, 8'h1a, 8'h40, 8'ha6, 8'h33};
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  opd_sequencer i_dut (.core_clk(core_clk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .cycle_kind(cycle_kind),
    .bus_rdata(bus_rdata), .index_pair(index_pair), .stack_pointer(stack_pointer),
    .store_data(store_data), .branch_taken(branch_taken), .opcode(opcode),
    .page_two(page_two), .operand(operand), .read_data(read_data), .bit_index(bit_index),
    .index_inc(index_inc), .push_done(push_done), .pop_done(pop_done),
    .instr_done(instr_done), .illegal_opcode(illegal_opcode));
  opd_mem_model i_mem (.core_clk(core_clk), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  // compare and count
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // move to just after the next rising edge
  task step;
    @(posedge core_clk);
    #1;
  endtask
  // check the bus cycle in progress, then let it end
  task cyc(input opd_pkg::opd_kind_t k, input logic [15:0] a);
    chk({13'h0000, cycle_kind}, {13'h0000, k});
    chk(bus_addr, a);
    step;
  endtask
  task t_reset;
    cyc(opd_pkg::KIND_VECTOR, 16'hfffe);
    reset_n = 1'b1;
    cyc(opd_pkg::KIND_VECTOR, 16'hfffe);
    cyc(opd_pkg::KIND_VECTOR, 16'hffff);
  endtask
  task t_ext;
    cyc(opd_pkg::KIND_FETCH, 16'h1000);
    cyc(opd_pkg::KIND_FETCH, 16'h1001);
    cyc(opd_pkg::KIND_FETCH, 16'h1002);
    cyc(opd_pkg::KIND_READ, 16'h1234);
    chk(read_data, 16'h005a);
    chk({15'h0000, instr_done}, 16'h0001);
  endtask
  task t_dir;
    cyc(opd_pkg::KIND_FETCH, 16'h1003);
    cyc(opd_pkg::KIND_FETCH, 16'h1004);
    cyc(opd_pkg::KIND_READ, 16'h0040);
    chk(read_data, 16'h0011);
  endtask
  task t_stack;
    cyc(opd_pkg::KIND_FETCH, 16'h1005);
    chk({bus_wr, bus_rd, bus_wdata}, 16'h02a5);
    cyc(opd_pkg::KIND_PUSH, 16'h0200);
    chk({push_done, instr_done, i_mem.mem[16'h0200]}, 16'h03a5);
    cyc(opd_pkg::KIND_FETCH, 16'h1006);
    cyc(opd_pkg::KIND_POP, 16'h0201);
    chk({pop_done, bus_rd, read_data}, 16'h033c);
    cyc(opd_pkg::KIND_FREE, 16'h1007);
    chk({15'h0000, instr_done}, 16'h0001);
  endtask
  task t_index;
    cyc(opd_pkg::KIND_FETCH, 16'h1007);
    cyc(opd_pkg::KIND_FETCH, 16'h1008);
    cyc(opd_pkg::KIND_READ, 16'h03ff);
    chk(read_data, 16'h0077);
  endtask
  task t_branch;
    int n;
    n = 0;
    branch_taken = 1'b1;
    cyc(opd_pkg::KIND_FETCH, 16'h1009);
    while (instr_done !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    chk(bus_addr, 16'h0f8b);
    n = 0;
    while (illegal_opcode !== 1'b1 && n < 8) begin
      step;
      n++;
    end
    chk({15'h0000, illegal_opcode}, 16'h0001);
  endtask
  task t_modes;
    branch_taken = 1'b0;
    cyc(opd_pkg::KIND_FETCH, 16'h0f8d);
    cyc(opd_pkg::KIND_FETCH, 16'h0f8e);
    cyc(opd_pkg::KIND_FETCH, 16'h0f8f);
    cyc(opd_pkg::KIND_READ, 16'h0400);
    chk(operand, 16'h0100);
    cyc(opd_pkg::KIND_FETCH, 16'h0f90);
    chk({15'h0000, page_two}, 16'h0001);
    cyc(opd_pkg::KIND_FETCH, 16'h0f91);
    cyc(opd_pkg::KIND_FETCH, 16'h0f92);
    cyc(opd_pkg::KIND_READ, 16'h0210);
    cyc(opd_pkg::KIND_FETCH, 16'h0f93);
    cyc(opd_pkg::KIND_FETCH, 16'h0f94);
    cyc(opd_pkg::KIND_READ, 16'h0300);
    chk({15'h0000, index_inc}, 16'h0001);
    cyc(opd_pkg::KIND_FREE, 16'h0f95);
    cyc(opd_pkg::KIND_FETCH, 16'h0f95);
    cyc(opd_pkg::KIND_FETCH, 16'h0f96);
    cyc(opd_pkg::KIND_FETCH, 16'h0f97);
    cyc(opd_pkg::KIND_FETCH, 16'h0f98);
    cyc(opd_pkg::KIND_READ, 16'h0208);
    cyc(opd_pkg::KIND_FETCH, 16'h0f99);
    chk({5'h00, bit_index, opcode}, 16'h051a);
    cyc(opd_pkg::KIND_FETCH, 16'h0f9a);
    cyc(opd_pkg::KIND_READ, 16'h0040);
    cyc(opd_pkg::KIND_WRITE, 16'h0040);
    cyc(opd_pkg::KIND_FREE, 16'h0f9b);
    cyc(opd_pkg::KIND_FETCH, 16'h0f9b);
    cyc(opd_pkg::KIND_FETCH, 16'h0f9c);
    chk({7'h00, instr_done, operand[7:0]}, 16'h0133);
  endtask
  // report counts and the verdict, then stop
  task test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    reset_n = 1'b0;
    branch_taken = 1'b0;
    index_pair = 16'h0300;
    stack_pointer = 16'h0200;
    store_data = 8'ha5;
    for (int i = 0; i < 65536; i++) begin
      i_mem.mem[i] = 8'h9d;
    end
    for (int i = 0; i < 11; i++) begin
      i_mem.mem[16'h1000 + i] = prog[i];
    end
    for (int i = 0; i < 16; i++) begin
      i_mem.mem[16'h0f8d + i] = prog2[i];
    end
    i_mem.mem[16'hfffe] = 8'h10;
    i_mem.mem[16'hffff] = 8'h00;
    i_mem.mem[16'h1234] = 8'h5a;
    i_mem.mem[16'h0040] = 8'h11;
    i_mem.mem[16'h0201] = 8'h3c;
    i_mem.mem[16'h03ff] = 8'h77;
    i_mem.mem[16'h0f8b] = 8'h9e;
    i_mem.mem[16'h0f8c] = 8'h9e;
    repeat (5) @(posedge core_clk);
    #1;
    t_reset;
    t_ext;
    t_dir;
    t_stack;
    t_index;
    t_branch;
    t_modes;
    test_done;
  end
endmodule

/* verification/opd_mem_model.sv */
`timescale 1ns/100ps
module opd_mem_model (
  // system bus from the sequencer
  input wire logic core_clk,
  input wire logic [15:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  // zero-wait read answer
  output logic [7:0] bus_rdata
);
  logic [7:0] mem [0:65535]; // whole address space, loaded by the bench
  logic [7:0] last = 8'h00; // last byte put on the bus
  // answer in the same cycle; outside reads show the inverse of the last byte
  assign bus_rdata = bus_rd ? mem[bus_addr] : ~last;
  // store at the edge that ends a write cycle
  always @(posedge core_clk) begin
    if (bus_wr) begin
      mem[bus_addr] <= bus_wdata;
    end
    if (bus_rd) begin
      last <= mem[bus_addr];
    end
  end
endmodule
